// >>> bench/lsx_mem_model.sv
`timescale 1ns/100ps
//----------------------------------------------------------------------
// Core memory model with adjustable answer delay
//----------------------------------------------------------------------
module lsx_mem_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Request side
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [1:0] mem_ben,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [3:0] lat,
	// Answer side
	output logic [15:0] mem_rdata,
	output logic mem_ack
);
	logic [15:0] mem [0:255];
	logic [3:0] wait_q;
	wire logic [7:0] a = mem_addr[7:0];

	assign mem_ack = mem_req && (wait_q == lat);
	// Data is only valid with ack; otherwise garbage
	assign mem_rdata = mem_ack ? mem[a] : ~mem[a];

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			wait_q <= 4'h0;
		else if (mem_ack || !mem_req)
			wait_q <= 4'h0;
		else
			wait_q <= wait_q + 4'h1;

	always @(posedge hclk)
		if (mem_ack && mem_we)
		begin
			if (mem_ben[0])
				mem[a][7:0] <= mem_wdata[7:0];
			if (mem_ben[1])
				mem[a][15:8] <= mem_wdata[15:8];
		end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
	typedef struct {logic [4:0] op; logic [15:0] iw, acc, mv; logic [5:0] st;
		logic [15:0] xa; logic [5:0] xs;} lsx_row_s;
	logic hclk, hresetn, hsel, hwrite, hreadyout, mem_req, mem_we, mem_ack, busy, done, irq_hold;
	logic [7:0] haddr;
	logic [1:0] htrans, mem_ben;
	logic [2:0] hsize;
	logic [3:0] lat;
	logic [31:0] hwdata, hrdata, d;
	logic [15:0] mem_addr, mem_wdata, mem_rdata;
	int err_count = 0;
	int tests_run = 0;
	int cyc_n = 0;
	int tus [12] = '{2, 3, 4, 5, 2, 2, 3, 3, 4, 4, 5, 5};
	logic [15:0] tiw [12] = '{16'h0200, 16'h0000, 16'h0e00, 16'h0c00, 16'h0200, 16'h0204,
		16'h0205, 16'h0208, 16'h0209, 16'h020c, 16'h020d, 16'h020f};
	lsx_row_s rows [17] = '{
		'{1, 16'h0200, 16'hffff, 16'h1234, 6'h2a, 16'h1234, 6'h2a},
		'{5, 16'h02ab, 16'hffff, 16'h0000, 6'h00, 16'h00ab, 6'h00},
		'{6, 16'h0200, 16'hffff, 16'h0000, 6'h29, 16'ha400, 6'h29},
		'{7, 16'h0200, 16'hb7ff, 16'h0000, 6'h00, 16'hb7ff, 6'h2d},
		'{14, 16'h0200, 16'h7fff, 16'h0001, 6'h00, 16'h8000, 6'h10},
		'{15, 16'h0001, 16'hffff, 16'h0000, 6'h00, 16'h0000, 6'h20},
		'{16, 16'h0200, 16'h0005, 16'h0000, 6'h20, 16'h0006, 6'h00},
		'{17, 16'h0200, 16'h8000, 16'h0001, 6'h00, 16'h7fff, 6'h30},
		'{18, 16'h00ff, 16'h0000, 16'h0000, 6'h00, 16'hff01, 6'h00},
		'{19, 16'h020f, 16'h8000, 16'h0000, 6'h00, 16'h8000, 6'h10},
		'{19, 16'h0200, 16'h0000, 16'h0000, 6'h00, 16'h0000, 6'h20},
		'{19, 16'h0200, 16'h0005, 16'h0000, 6'h00, 16'hfffb, 6'h00},
		'{20, 16'h0200, 16'hfffb, 16'h0000, 6'h00, 16'h0005, 6'h00},
		'{20, 16'h0200, 16'h8000, 16'h0000, 6'h00, 16'h8000, 6'h10},
		'{20, 16'h0200, 16'h0005, 16'h0000, 6'h30, 16'h0005, 6'h30},
		'{21, 16'h0200, 16'hf0f0, 16'hff00, 6'h00, 16'hf000, 6'h00},
		'{22, 16'h0200, 16'hf0f0, 16'hff00, 6'h00, 16'hfff0, 6'h00}};

	lsx_exec u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .mem_req(mem_req), .mem_we(mem_we),
		.mem_ben(mem_ben), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .busy(busy), .done(done), .irq_hold(irq_hold));
	lsx_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_we(mem_we),
		.mem_ben(mem_ben), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));

	//------------------------------------------------------------------
	// Bus tasks
	//------------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (!hreadyout)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (!hreadyout)
			@(posedge hclk);
		d = hrdata;
	endtask

	task automatic ex(input logic [4:0] op, input logic [15:0] iw, ea, input logic [1:0] lv);
		int n;
		xfer(1'b1, lsx_pkg::REG_INSTR, {16'h0, iw});
		xfer(1'b1, lsx_pkg::REG_EA, {16'h0, ea});
		xfer(1'b1, lsx_pkg::REG_CTRL, {14'h0, lv, 3'h0, op, 7'h0, 1'b1});
		@(posedge hclk);
		chk({31'h0, busy}, 32'h1);
		n = 1;
		while (!done && n < 3000)
		begin
			@(posedge hclk);
			n++;
		end
		cyc_n = n;
		chk({31'h0, done}, 32'h1);
		chk({31'h0, busy}, 32'h0);
	endtask

	task summarize;
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	//------------------------------------------------------------------
	// Stimulus
	//------------------------------------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	initial
	begin
		#200000;
		err_count++;
		summarize;
	end

	initial
	begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, lat} = '0;
		hsize = 3'h2;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i])
		begin
			u_mem.mem[8'h60] = rows[i].mv;
			xfer(1'b1, lsx_pkg::REG_ACC, {16'h0, rows[i].acc});
			xfer(1'b1, lsx_pkg::REG_STAT, {26'h0, rows[i].st});
			ex(rows[i].op, rows[i].iw, 16'h0060, 2'h0);
			xfer(1'b0, lsx_pkg::REG_ACC, 32'h0);
			chk(d, {16'h0, rows[i].xa});
			xfer(1'b0, lsx_pkg::REG_STAT, 32'h0);
			chk(d, {26'h0, rows[i].xs});
			chk({31'h0, irq_hold}, {31'h0, rows[i].op == 5 || rows[i].op == 6});
		end
		$display("test arith done");
		u_mem.mem[8'h50] = 16'hffff;
		u_mem.mem[8'h51] = 16'hffff;
		lat <= 4'h5;
		xfer(1'b1, lsx_pkg::REG_ACC, 32'h1234);
		ex(8, 16'h0200, 16'h0050, 2'h0);
		ex(10, 16'h0200, 16'h0051, 2'h0);
		ex(9, 16'h0200, 16'h0052, 2'h0);
		chk({16'h0, u_mem.mem[8'h50]}, 32'hff34);
		chk({16'h0, u_mem.mem[8'h51]}, 32'h34ff);
		chk({16'h0, u_mem.mem[8'h52]}, 32'h1234);
		$display("test store done");
		{u_mem.mem[8'h60], u_mem.mem[8'h30], u_mem.mem[8'h33]} = {16'h30, 16'h40, 16'h1111};
		u_mem.mem[8'h42] = 16'h2222;
		ex(2, 16'h0200, 16'h0060, 2'h1);
		xfer(1'b0, lsx_pkg::REG_INDEX, 32'h0);
		chk(d, 32'h30);
		ex(3, 16'h0003, 16'h0000, 2'h1);
		xfer(1'b0, lsx_pkg::REG_ACC, 32'h0);
		chk(d, 32'h1111);
		ex(4, 16'h0002, 16'h0000, 2'h1);
		xfer(1'b0, lsx_pkg::REG_ACC, 32'h0);
		chk(d, 32'h2222);
		ex(12, 16'h0005, 16'h0000, 2'h1);
		ex(13, 16'h0006, 16'h0000, 2'h1);
		ex(11, 16'h0200, 16'h0070, 2'h1);
		chk({16'h0, u_mem.mem[8'h35]}, 32'h2222);
		chk({16'h0, u_mem.mem[8'h46]}, 32'h2222);
		chk({16'h0, u_mem.mem[8'h70]}, 32'h30);
		ex(0, 16'h0200, 16'h0000, 2'h0);
		xfer(1'b0, lsx_pkg::REG_INDEX, 32'h0);
		chk(d, 32'h0);
		$display("test index done");
		lat <= 4'h0;
		foreach (tiw[i])
		begin
			ex(i < 3 ? 5'd1 : (i == 3 ? 5'd9 : 5'd23), tiw[i], 16'h0060, 2'h0);
			xfer(1'b0, lsx_pkg::REG_INFO, 32'h0);
			chk({20'h0, d[27:16]}, tus[i] * 250);
			chk(cyc_n, tus[i] * 250 + 2);
		end
		$display("test timing done");
		summarize;
	end
endmodule

// >>> logic/lsx_addsub.sv
`timescale 1ns/100ps
module lsx_addsub #(
	parameter int W = 16
) (
	// Operands
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic sub,
	// Result
	output logic [W-1:0] sum,
	output logic cout,
	output logic ovf
);
	logic [W-1:0] b_eff;
	logic [W:0] full;

	assign b_eff = sub ? ~b : b;
	assign full = {1'b0, a} + {1'b0, b_eff} + {{W{1'b0}}, sub};
	assign sum = full[W-1:0];
	// Carry out of the sign position
	assign cout = full[W];
	// Fraction left the range -1.0 .. 1.0-2^-15
	assign ovf = (a[W-1] == b_eff[W-1]) && (sum[W-1] != a[W-1]);
endmodule

// >>> logic/lsx_exec.sv
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
//----------------------------------------------------------------------
// Load, store, arithmetic and logic execution unit
//----------------------------------------------------------------------
module lsx_exec #(
	parameter int ADDR_W = 8,
	parameter int LEVELS = 4
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Core memory port
	output logic mem_req,
	output logic mem_we,
	output logic [1:0] mem_ben,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack,
	// Execution status
	output logic busy,
	output logic done,
	output logic irq_hold
);
	localparam int LW = (LEVELS > 1) ? $clog2(LEVELS) : 1;
	typedef enum logic [2:0] {
		ST_IDLE, ST_DISPATCH, ST_PTR, ST_OPND, ST_STORE, ST_EXEC, ST_WAIT
	} lsx_state_e;

	lsx_state_e state_q;
	lsx_pkg::lsx_op_e op_q;
	logic [LW-1:0] level_q;
	logic [15:0] instr_q, ea_q, acc_q, opnd_q;
	logic [15:0] idx_q [LEVELS];
	logic [lsx_pkg::ST_W-1:0] stat_q [LEVELS];
	logic [lsx_pkg::TIME_W-1:0] timer_q, time_q, elapsed_q;
	logic busy_q, done_q, hold_q;
	logic mem_req_q, mem_we_q;
	logic [1:0] mem_ben_q;
	logic [15:0] mem_addr_q, mem_wdata_q;
	logic wr_pend_q, rd_pend_q, hreadyout_q;
	logic [ADDR_W-1:0] dp_addr_q;
	logic [31:0] hrdata_q;

	//------------------------------------------------------------------
	// Decode
	//------------------------------------------------------------------
	logic [7:0] immediate_byte_field;
	logic [2:0] address_mode_tags;
	logic [3:0] disp;
	logic [15:0] idx_cur, addr_xd, addr_pn, st_data;
	logic [lsx_pkg::ST_W-1:0] stat_cur;
	logic is_xd, is_pn, is_rd, is_wr, is_mem, is_neg, is_imm, is_sub;
	lsx_pkg::lsx_cls_e cls;
	logic [1:0] st_ben;
	logic [lsx_pkg::TIME_W-1:0] time_cyc;

	assign immediate_byte_field = instr_q[7:0];
	assign address_mode_tags = instr_q[lsx_pkg::IW_TAG_LSB +: 3];
	assign disp = instr_q[3:0];
	assign idx_cur = idx_q[level_q];
	assign stat_cur = stat_q[level_q];
	assign addr_xd = idx_cur + {12'h000, disp};
	assign addr_pn = mem_rdata + {12'h000, disp};
	assign is_xd = op_q == lsx_pkg::OP_LOAD_ACC_INDEX_DISP
		|| op_q == lsx_pkg::OP_STORE_ACC_INDEX_DISP;
	assign is_pn = op_q == lsx_pkg::OP_LOAD_ACC_INDEX_INDIRECT_DISP
		|| op_q == lsx_pkg::OP_ST_ACC_INDEX_INDIRECT_DISP;
	assign is_mem = op_q inside {lsx_pkg::OP_LD_ACC, lsx_pkg::OP_LD_IDX,
		lsx_pkg::OP_ADD_MEM, lsx_pkg::OP_SUB_MEM, lsx_pkg::OP_AND_MEM, lsx_pkg::OP_OR_MEM,
		lsx_pkg::OP_STORE_LOW_BYTE_RIGHT, lsx_pkg::OP_ST_BYTE_LEFT,
		lsx_pkg::OP_ST_ACC, lsx_pkg::OP_ST_IDX};
	assign is_wr = op_q inside {lsx_pkg::OP_STORE_LOW_BYTE_RIGHT, lsx_pkg::OP_ST_BYTE_LEFT,
		lsx_pkg::OP_ST_ACC, lsx_pkg::OP_ST_IDX, lsx_pkg::OP_STORE_ACC_INDEX_DISP,
		lsx_pkg::OP_ST_ACC_INDEX_INDIRECT_DISP};
	assign is_rd = (is_mem || is_xd || is_pn) && !is_wr;
	assign cls = is_mem ? lsx_pkg::CLS_MEM :
		(op_q == lsx_pkg::OP_SHIFT_TIME) ? lsx_pkg::CLS_SHIFT : lsx_pkg::CLS_REG;
	// Store data and byte lanes; ben[1] is the high byte
	assign st_data = (op_q == lsx_pkg::OP_STORE_LOW_BYTE_RIGHT) ? {8'h00, acc_q[7:0]} :
		(op_q == lsx_pkg::OP_ST_BYTE_LEFT) ? {acc_q[7:0], 8'h00} :
		(op_q == lsx_pkg::OP_ST_IDX) ? idx_cur : acc_q;
	assign st_ben = (op_q == lsx_pkg::OP_STORE_LOW_BYTE_RIGHT) ? lsx_pkg::BEN_LOW :
		(op_q == lsx_pkg::OP_ST_BYTE_LEFT) ? lsx_pkg::BEN_HIGH : lsx_pkg::BEN_WORD;

	lsx_time u_time (
		.cls(cls),
		.ind(address_mode_tags[2]),
		.idx(address_mode_tags[1]),
		.page(address_mode_tags[0]),
		.shift_n(disp),
		.cycles(time_cyc)
	);

	//------------------------------------------------------------------
	// Arithmetic
	//------------------------------------------------------------------
	logic [15:0] alu_a, alu_b, alu_sum;
	logic alu_cout, alu_ovf;

	assign is_neg = op_q == lsx_pkg::OP_NEGATE || op_q == lsx_pkg::OP_ABSOLUTE;
	assign is_imm = op_q == lsx_pkg::OP_ADD_IMM || op_q == lsx_pkg::OP_SUB_IMM;
	assign is_sub = op_q inside {lsx_pkg::OP_SUB_MEM, lsx_pkg::OP_SUB_IMM} || is_neg;
	assign alu_a = is_neg ? 16'h0000 : acc_q;
	assign alu_b = is_neg ? acc_q : is_imm ? {8'h00, immediate_byte_field} :
		(op_q == lsx_pkg::OP_ADD_CARRY) ? {15'h0000, stat_cur[lsx_pkg::ST_C]} :
		opnd_q;

	lsx_addsub #(
		.W(lsx_pkg::DW)
	) u_addsub (
		.a(alu_a),
		.b(alu_b),
		.sub(is_sub),
		.sum(alu_sum),
		.cout(alu_cout),
		.ovf(alu_ovf)
	);

	logic [15:0] acc_d, idx_d;
	logic [lsx_pkg::ST_W-1:0] stat_d;

	always_comb
	begin
		acc_d = acc_q;
		idx_d = idx_cur;
		stat_d = stat_cur;
		case (op_q)
			lsx_pkg::OP_LD_ACC, lsx_pkg::OP_LOAD_ACC_INDEX_DISP,
			lsx_pkg::OP_LOAD_ACC_INDEX_INDIRECT_DISP: acc_d = opnd_q;
			lsx_pkg::OP_LD_IDX: idx_d = opnd_q;
			lsx_pkg::OP_LD_BYTE_IMM: acc_d = {8'h00, immediate_byte_field};
			lsx_pkg::OP_STAT_TO_ACC: acc_d = {stat_cur, 10'h000};
			lsx_pkg::OP_ACC_TO_STAT: stat_d = acc_q[15:10];
			lsx_pkg::OP_ADD_MEM, lsx_pkg::OP_ADD_IMM, lsx_pkg::OP_ADD_CARRY,
			lsx_pkg::OP_SUB_MEM, lsx_pkg::OP_SUB_IMM:
			begin
				acc_d = alu_sum;
				stat_d[lsx_pkg::ST_C] = alu_cout;
				stat_d[lsx_pkg::ST_V] = alu_ovf;
			end
			lsx_pkg::OP_NEGATE:
			begin
				acc_d = alu_ovf ? acc_q : alu_sum;
				stat_d[lsx_pkg::ST_C] = alu_cout;
				stat_d[lsx_pkg::ST_V] = alu_ovf;
			end
			lsx_pkg::OP_ABSOLUTE:
			begin
				if (acc_q[15])
				begin
					acc_d = alu_ovf ? acc_q : alu_sum;
					stat_d[lsx_pkg::ST_V] = alu_ovf;
				end
			end
			lsx_pkg::OP_AND_MEM: acc_d = acc_q & opnd_q;
			lsx_pkg::OP_OR_MEM: acc_d = acc_q | opnd_q;
			default: acc_d = acc_q;
		endcase
	end

	//------------------------------------------------------------------
	// Bus slave
	//------------------------------------------------------------------
	logic ahb_take, sw_idle, sw_wr, start, exec_now;
	logic [31:0] rd_ctrl, rd_info, rd_mux;

	assign ahb_take = hsel && htrans[1] && hready;
	assign sw_idle = state_q == ST_IDLE;
	assign sw_wr = wr_pend_q && sw_idle;
	assign start = sw_wr && dp_addr_q == ADDR_W'(lsx_pkg::REG_CTRL)
		&& hwdata[lsx_pkg::CTRL_START_BIT];
	assign exec_now = state_q == ST_EXEC;
	assign rd_ctrl = (32'(level_q) << lsx_pkg::CTRL_LVL_LSB)
		| (32'(op_q) << lsx_pkg::CTRL_OP_LSB) | {31'h00000000, busy_q};
	assign rd_info = (32'(time_q) << lsx_pkg::INFO_TIME_LSB)
		| (32'(hold_q) << lsx_pkg::INFO_HOLD_BIT) | {31'h00000000, busy_q};
	assign rd_mux = (dp_addr_q == ADDR_W'(lsx_pkg::REG_CTRL)) ? rd_ctrl :
		(dp_addr_q == ADDR_W'(lsx_pkg::REG_INSTR)) ? {16'h0000, instr_q} :
		(dp_addr_q == ADDR_W'(lsx_pkg::REG_EA)) ? {16'h0000, ea_q} :
		(dp_addr_q == ADDR_W'(lsx_pkg::REG_ACC)) ? {16'h0000, acc_q} :
		(dp_addr_q == ADDR_W'(lsx_pkg::REG_STAT)) ? {26'h0000000, stat_cur} :
		(dp_addr_q == ADDR_W'(lsx_pkg::REG_INDEX)) ? {16'h0000, idx_cur} :
		(dp_addr_q == ADDR_W'(lsx_pkg::REG_INFO)) ? rd_info : 32'h00000000;

	// Reads take one wait state so a preceding write is seen
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			dp_addr_q <= '0;
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h00000000;
		end
		else
		begin
			wr_pend_q <= ahb_take && hwrite;
			rd_pend_q <= ahb_take && !hwrite;
			hreadyout_q <= !(ahb_take && !hwrite);
			if (ahb_take)
				dp_addr_q <= {haddr[ADDR_W-1:2], 2'b00};
			if (rd_pend_q)
				hrdata_q <= rd_mux;
		end
	end

	//------------------------------------------------------------------
	// Register file
	//------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			acc_q <= 16'h0000;
			instr_q <= 16'h0000;
			ea_q <= 16'h0000;
			op_q <= lsx_pkg::OP_NOP;
			level_q <= '0;
			hold_q <= 1'b0;
			for (int i = 0; i < LEVELS; i++)
			begin
				idx_q[i] <= 16'h0000;
				stat_q[i] <= '0;
			end
		end
		else if (exec_now)
		begin
			acc_q <= acc_d;
			idx_q[level_q] <= idx_d;
			stat_q[level_q] <= stat_d;
			hold_q <= op_q inside {lsx_pkg::OP_LD_BYTE_IMM, lsx_pkg::OP_STAT_TO_ACC};
		end
		else if (sw_wr)
		begin
			case (dp_addr_q)
				ADDR_W'(lsx_pkg::REG_CTRL):
				begin
					op_q <= lsx_pkg::lsx_op_e'(hwdata[lsx_pkg::CTRL_OP_LSB +: 5]);
					level_q <= hwdata[lsx_pkg::CTRL_LVL_LSB +: LW];
					if (start)
						hold_q <= 1'b0;
				end
				ADDR_W'(lsx_pkg::REG_INSTR): instr_q <= hwdata[15:0];
				ADDR_W'(lsx_pkg::REG_EA): ea_q <= hwdata[15:0];
				ADDR_W'(lsx_pkg::REG_ACC): acc_q <= hwdata[15:0];
				ADDR_W'(lsx_pkg::REG_STAT): stat_q[level_q] <= hwdata[lsx_pkg::ST_W-1:0];
				ADDR_W'(lsx_pkg::REG_INDEX): idx_q[level_q] <= hwdata[15:0];
				default: hold_q <= hold_q;
			endcase
		end
	end

	//------------------------------------------------------------------
	// Sequencer and memory port
	//------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q <= ST_IDLE;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			timer_q <= '0;
			time_q <= '0;
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_ben_q <= lsx_pkg::BEN_WORD;
			mem_addr_q <= 16'h0000;
			mem_wdata_q <= 16'h0000;
			opnd_q <= 16'h0000;
		end
		else
		begin
			done_q <= 1'b0;
			if (timer_q != '0)
				timer_q <= timer_q - 1'b1;
			case (state_q)
				ST_IDLE:
					if (start)
					begin
						busy_q <= 1'b1;
						state_q <= ST_DISPATCH;
					end
				ST_DISPATCH:
				begin
					timer_q <= time_cyc;
					time_q <= time_cyc;
					mem_ben_q <= lsx_pkg::BEN_WORD;
					mem_we_q <= 1'b0;
					mem_req_q <= is_rd || is_wr;
					mem_addr_q <= is_pn ? idx_cur : is_xd ? addr_xd : ea_q;
					if (is_pn)
						state_q <= ST_PTR;
					else if (is_wr)
					begin
						mem_we_q <= 1'b1;
						mem_ben_q <= st_ben;
						mem_wdata_q <= st_data;
						state_q <= ST_STORE;
					end
					else if (is_rd)
						state_q <= ST_OPND;
					else
						state_q <= ST_EXEC;
				end
				ST_PTR:
					if (mem_ack)
					begin
						mem_addr_q <= addr_pn;
						mem_we_q <= is_wr;
						mem_ben_q <= st_ben;
						mem_wdata_q <= st_data;
						state_q <= is_wr ? ST_STORE : ST_OPND;
					end
				ST_OPND:
					if (mem_ack)
					begin
						opnd_q <= mem_rdata;
						mem_req_q <= 1'b0;
						state_q <= ST_EXEC;
					end
				ST_STORE:
					if (mem_ack)
					begin
						mem_req_q <= 1'b0;
						mem_we_q <= 1'b0;
						state_q <= ST_WAIT;
					end
				ST_EXEC: state_q <= ST_WAIT;
				ST_WAIT:
					if (timer_q <= 1)
					begin
						busy_q <= 1'b0;
						done_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0;
	assign mem_req = mem_req_q;
	assign mem_we = mem_we_q;
	assign mem_ben = mem_ben_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign busy = busy_q;
	assign done = done_q;
	assign irq_hold = hold_q;

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			elapsed_q <= '0;
		else if (state_q == ST_DISPATCH)
			elapsed_q <= 12'h001;
		else if (busy_q && elapsed_q != '1)
			elapsed_q <= elapsed_q + 1'b1;
	end

	a_time_floor: assert property (@(posedge hclk) disable iff (!hresetn)
		done_q |-> elapsed_q > time_q)
		else $error("instruction ended before its execution time");
	a_load_acc: assert property (@(posedge hclk) disable iff (!hresetn)
		exec_now && op_q == lsx_pkg::OP_LD_ACC |=> acc_q == $past(opnd_q)
		&& stat_cur == $past(stat_cur))
		else $error("accumulator load wrong");
	a_xd_address: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_DISPATCH && op_q == lsx_pkg::OP_LOAD_ACC_INDEX_DISP
		|=> mem_req_q && mem_addr_q == $past(idx_cur) + {12'h000, $past(disp)})
		else $error("indexed load address wrong");
	a_byte_imm: assert property (@(posedge hclk) disable iff (!hresetn)
		exec_now && op_q == lsx_pkg::OP_LD_BYTE_IMM
		|=> acc_q == {8'h00, $past(immediate_byte_field)})
		else $error("byte immediate load wrong");
	a_irq_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		exec_now && op_q == lsx_pkg::OP_STAT_TO_ACC |=> hold_q [*2])
		else $error("interrupt hold not raised");
	a_stat_read: assert property (@(posedge hclk) disable iff (!hresetn)
		exec_now && op_q == lsx_pkg::OP_STAT_TO_ACC
		|=> acc_q[9:0] == 10'h000 && acc_q[15:10] == $past(stat_cur))
		else $error("status read wrong");
	a_byte_lane: assert property (@(posedge hclk) disable iff (!hresetn)
		state_q == ST_STORE && op_q == lsx_pkg::OP_STORE_LOW_BYTE_RIGHT
		|-> mem_we_q && mem_ben_q == lsx_pkg::BEN_LOW && mem_wdata_q[7:0] == acc_q[7:0])
		else $error("right byte store lanes wrong");
	a_neg_min: assert property (@(posedge hclk) disable iff (!hresetn)
		exec_now && op_q == lsx_pkg::OP_NEGATE && acc_q == lsx_pkg::ACC_MOST_NEG
		|=> acc_q == lsx_pkg::ACC_MOST_NEG && stat_cur[lsx_pkg::ST_V])
		else $error("negate of most negative wrong");
	a_abs_pos: assert property (@(posedge hclk) disable iff (!hresetn)
		exec_now && op_q == lsx_pkg::OP_ABSOLUTE && !acc_q[15] |=> $stable(acc_q))
		else $error("absolute value changed a positive value");
	a_sub_carry: assert property (@(posedge hclk) disable iff (!hresetn)
		exec_now && op_q == lsx_pkg::OP_SUB_MEM
		|=> {stat_cur[lsx_pkg::ST_C], acc_q} == {1'b0, $past(acc_q)} + {1'b0, ~$past(opnd_q)}
		+ 17'h00001)
		else $error("subtract result or carry wrong");
endmodule

// >>> logic/lsx_pkg.sv
//----------------------------------------------------------------------
// Shared constants for the execution unit
//----------------------------------------------------------------------
package lsx_pkg;
	localparam int DW = 16;
	localparam int ST_W = 6;
	localparam int TIME_W = 12;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_INSTR = 8'h04;
	localparam logic [7:0] REG_EA = 8'h08;
	localparam logic [7:0] REG_ACC = 8'h0c;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_INDEX = 8'h14;
	localparam logic [7:0] REG_INFO = 8'h18;

	// Control and info fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_OP_LSB = 8;
	localparam int CTRL_LVL_LSB = 16;
	localparam int INFO_HOLD_BIT = 1;
	localparam int INFO_TIME_LSB = 16;

	// Instruction word, vector index is 15 minus printed bit
	localparam int IW_TAG_LSB = 9;
	localparam int IW_I_BIT = 11;
	localparam int IW_X_BIT = 10;
	localparam int IW_P_BIT = 9;

	// Status word, carry at the top like accumulator bit 0
	localparam int ST_C = 5;
	localparam int ST_V = 4;
	localparam logic [15:0] ACC_MOST_NEG = 16'h8000;
	localparam logic [1:0] BEN_WORD = 2'h3;
	localparam logic [1:0] BEN_LOW = 2'h1;
	localparam logic [1:0] BEN_HIGH = 2'h2;

	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int NS_PER_US = 1000;
	localparam int STEP_US = 1;
	localparam int CYC_PER_US = (STEP_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] BASE_US = 4'h2;
	localparam logic [3:0] SHIFT_N_A = 4'h4;
	localparam logic [3:0] SHIFT_N_B = 4'h8;
	localparam logic [3:0] SHIFT_N_C = 4'hc;
	localparam logic [3:0] SHIFT_US_A = 4'h2;
	localparam logic [3:0] SHIFT_US_B = 4'h3;
	localparam logic [3:0] SHIFT_US_C = 4'h4;
	localparam logic [3:0] SHIFT_US_D = 4'h5;

	typedef enum logic [4:0] {
		OP_NOP, OP_LD_ACC, OP_LD_IDX, OP_LOAD_ACC_INDEX_DISP,
		OP_LOAD_ACC_INDEX_INDIRECT_DISP, OP_LD_BYTE_IMM, OP_STAT_TO_ACC,
		OP_ACC_TO_STAT, OP_STORE_LOW_BYTE_RIGHT, OP_ST_ACC, OP_ST_BYTE_LEFT,
		OP_ST_IDX, OP_STORE_ACC_INDEX_DISP, OP_ST_ACC_INDEX_INDIRECT_DISP,
		OP_ADD_MEM, OP_ADD_IMM, OP_ADD_CARRY, OP_SUB_MEM, OP_SUB_IMM,
		OP_NEGATE, OP_ABSOLUTE, OP_AND_MEM, OP_OR_MEM, OP_SHIFT_TIME
	} lsx_op_e;

	typedef enum logic [1:0] {CLS_REG, CLS_MEM, CLS_SHIFT} lsx_cls_e;
endpackage

// >>> logic/lsx_time.sv
`timescale 1ns/100ps
module lsx_time (
	// Instruction class and fields
	input wire lsx_pkg::lsx_cls_e cls,
	input wire logic ind,
	input wire logic idx,
	input wire logic page,
	input wire logic [3:0] shift_n,
	// Execution time
	output logic [lsx_pkg::TIME_W-1:0] cycles
);
	localparam int TW = lsx_pkg::TIME_W;
	logic [3:0] mem_us;
	logic [3:0] shift_us;
	logic [3:0] us;

	assign mem_us = lsx_pkg::BASE_US + {3'h0, ind} + {3'h0, idx} + {3'h0, ~page};
	assign shift_us = (shift_n <= lsx_pkg::SHIFT_N_A) ? lsx_pkg::SHIFT_US_A :
		(shift_n <= lsx_pkg::SHIFT_N_B) ? lsx_pkg::SHIFT_US_B :
		(shift_n <= lsx_pkg::SHIFT_N_C) ? lsx_pkg::SHIFT_US_C : lsx_pkg::SHIFT_US_D;
	assign us = (cls == lsx_pkg::CLS_MEM) ? mem_us :
		(cls == lsx_pkg::CLS_SHIFT) ? shift_us : lsx_pkg::BASE_US;
	assign cycles = TW'(int'(us) * lsx_pkg::CYC_PER_US);
endmodule
